// >>> rtl/bch_pkg.sv
// Constants for the bridge configuration header tail: offsets, fields, resets, timer counts.
// Assumes a single PCI clock domain and an asynchronous active-low reset.
//
// Contract
// - The capability pointer is read-only and always returns the power management block offset.
// - The option ROM base register is read-only and always reads as zero.
// - The interrupt line byte is a plain read/write store, reset to zero, steering nothing.
// - The interrupt pin byte is read-only and reads as zero.
// - Bridge control bits 15 to 12 read as zero and ignore writes.
// - With bit 11 set, a primary discard timer expiry signals a system error upstream.
// - Bit 10 is set whenever either discard timer expires and a delayed transaction is dropped.
// - Bit 10 stays set until software writes a one to it; writing zero leaves it alone.
// - Bit 9 selects the secondary discard timeout: 2^15 clocks when zero, 2^10 when one.
// - Bit 8 selects the primary discard timeout: 2^15 clocks when zero, 2^10 when one.
// - A discard timer reaching its count drops the delayed transaction from the queue.
// - Bit 7 reads as zero and ignores writes.
// - While bit 6 is one the secondary bus reset output is active.
// - The whole bridge control register resets to zero.
// - System error is driven upstream only when the command register error enable is set.
package bch_pkg;

   // Dword-aligned configuration byte offsets
   localparam logic [7:0] BCH_OFS_CAP_HEAD   = 8'h34;
   localparam logic [7:0] BCH_OFS_ROM_BASE   = 8'h38;
   localparam logic [7:0] BCH_OFS_IRQ_DWORD  = 8'h3c;
   // Byte offsets inside the last dword
   localparam logic [7:0] BCH_OFS_IRQ_NOTE   = 8'h3c;
   localparam logic [7:0] BCH_OFS_IRQ_TERM   = 8'h3d;
   localparam logic [7:0] BCH_OFS_SEC_CTRL   = 8'h3e;

   // Reset and fixed values
   localparam logic [7:0]  BCH_CAP_HEAD_VAL   = 8'hdc;
   localparam logic [31:0] BCH_ROM_BASE_VAL   = 32'h0000_0000;
   localparam logic [7:0]  BCH_IRQ_NOTE_RST   = 8'h00;
   localparam logic [7:0]  BCH_IRQ_TERM_VAL   = 8'h00;
   localparam logic [15:0] BCH_SEC_CTRL_RST   = 16'h0000;

   // Bridge control field positions
   localparam int BCH_BIT_DISC_SERR_EN = 11;
   localparam int BCH_BIT_DISC_STATUS  = 10;
   localparam int BCH_BIT_SEC_DISC_SEL = 9;
   localparam int BCH_BIT_PRI_DISC_SEL = 8;
   localparam int BCH_BIT_FAST_B2B     = 7;
   localparam int BCH_BIT_SEC_RESET    = 6;

   // Discard timer counts in PCI clocks
   localparam int BCH_DISC_LONG_EXP    = 15;
   localparam int BCH_DISC_SHORT_EXP   = 10;
   localparam int BCH_DISC_LONG_CLKS   = 1 << BCH_DISC_LONG_EXP;
   localparam int BCH_DISC_SHORT_CLKS  = 1 << BCH_DISC_SHORT_EXP;
   localparam int BCH_DISC_CNT_W       = 16;

endpackage : bch_pkg

// >>> rtl/bch_discard_timer.sv
// One delayed-transaction discard timer.
// Assumes start, repeat and select come from logic on the same PCI clock.
module bch_discard_timer #(
   parameter int LONG_CLKS  = bch_pkg::BCH_DISC_LONG_CLKS,
   parameter int SHORT_CLKS = bch_pkg::BCH_DISC_SHORT_CLKS
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rstn,
   // Control
   input  wire logic start,
   input  wire logic master_repeat,
   input  wire logic short_sel,
   // Status
   output logic      running,
   output logic      expire
);
   import bch_pkg::*;

   logic [BCH_DISC_CNT_W-1:0] count;
   logic [BCH_DISC_CNT_W-1:0] limit;
   logic                      hit;

   assign limit = short_sel ? BCH_DISC_CNT_W'(SHORT_CLKS) : BCH_DISC_CNT_W'(LONG_CLKS);
   assign hit   = running && !master_repeat && (count >= limit);

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         count   <= '0;
         running <= 1'b0;
         expire  <= 1'b0;
      end else begin
         expire <= hit;
         if (start) begin
            running <= 1'b1;
            count   <= BCH_DISC_CNT_W'(1);
         end else if (master_repeat || hit) begin
            running <= 1'b0;
            count   <= '0;
         end else if (running) begin
            count <= count + BCH_DISC_CNT_W'(1);
         end
      end
   end

endmodule : bch_discard_timer

// >>> rtl/bch_config_tail.sv
// Tail of the bridge configuration header: capability pointer, option ROM base,
// interrupt bytes and the upper bridge control bits, with both discard timers.
// Assumes config cycles are already decoded to a one-cycle request on the PCI clock.
module bch_config_tail
   import bch_pkg::*;
#(
   parameter int LONG_CLKS  = bch_pkg::BCH_DISC_LONG_CLKS,
   parameter int SHORT_CLKS = bch_pkg::BCH_DISC_SHORT_CLKS
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rstn,
   // Configuration access
   input  wire logic        cfg_req,
   input  wire logic        cfg_write,
   input  wire logic [7:0]  cfg_addr,
   input  wire logic [3:0]  cfg_byte_en_n,
   input  wire logic [31:0] cfg_wdata,
   output logic             cfg_ack,
   output logic             cfg_hit,
   output logic [31:0]      cfg_rdata,
   // Primary command register
   input  wire logic        serr_enable,
   // Delayed transaction events
   input  wire logic        pri_dt_complete,
   input  wire logic        pri_dt_repeat,
   input  wire logic        sec_dt_complete,
   input  wire logic        sec_dt_repeat,
   output logic             pri_dt_discard,
   output logic             sec_dt_discard,
   // Upstream system error, open drain
   output logic             upstream_system_error_out,
   output logic             upstream_system_error_oe_n,
   // Secondary bus reset
   output logic             sec_bus_reset_n
);
   import bch_pkg::*;

   logic [7:0]  irq_routing_note;
   logic        disc_serr_en;
   logic        disc_status;
   logic        sec_disc_sel;
   logic        pri_disc_sel;
   logic        sec_reset;
   logic        serr_drive;

   logic        pri_running;
   logic        sec_running;
   logic        pri_expire;
   logic        sec_expire;

   // Address decode
   wire         sel_cap   = cfg_addr[7:2] == BCH_OFS_CAP_HEAD[7:2];
   wire         sel_rom   = cfg_addr[7:2] == BCH_OFS_ROM_BASE[7:2];
   wire         sel_irq   = cfg_addr[7:2] == BCH_OFS_IRQ_DWORD[7:2];
   wire         hit       = sel_cap || sel_rom || sel_irq;
   wire         wr_irq    = cfg_req && cfg_write && sel_irq;
   wire         wr_note   = wr_irq && !cfg_byte_en_n[BCH_OFS_IRQ_NOTE[1:0]];
   wire         wr_ctl_lo = wr_irq && !cfg_byte_en_n[BCH_OFS_SEC_CTRL[1:0]];
   wire         wr_ctl_hi = wr_irq && !cfg_byte_en_n[BCH_OFS_SEC_CTRL[1:0] + 2'd1];
   wire  [15:0] ctl_wdata = cfg_wdata[31:16];

   // Bridge control image; unlisted bits read zero
   wire  [15:0] sec_ctrl_rd = {4'h0,
                               disc_serr_en, disc_status, sec_disc_sel, pri_disc_sel,
                               1'b0,
                               sec_reset, 6'h00};

   // Read data selection; read-only values are constants
   wire  [31:0] rd_mux = sel_cap ? {24'h00_0000, BCH_CAP_HEAD_VAL} :
                         sel_rom ? BCH_ROM_BASE_VAL :
                         sel_irq ? {sec_ctrl_rd, BCH_IRQ_TERM_VAL, irq_routing_note} :
                                   32'h0000_0000;

   // Discard status: a set in the same cycle as a write-one clear wins
   wire         disc_event = pri_expire || sec_expire;
   wire         disc_clear = wr_ctl_hi && ctl_wdata[BCH_BIT_DISC_STATUS];
   wire         next_disc_status = disc_event ? 1'b1 :
                                   disc_clear ? 1'b0 : disc_status;

   wire         serr_req = pri_expire && disc_serr_en && serr_enable;
   wire         next_sec_reset_val = wr_ctl_lo ? ctl_wdata[BCH_BIT_SEC_RESET] : sec_reset;

   // Bus answer
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cfg_ack   <= 1'b0;
         cfg_hit   <= 1'b0;
         cfg_rdata <= 32'h0000_0000;
      end else begin
         cfg_ack   <= cfg_req;
         cfg_hit   <= cfg_req && hit;
         cfg_rdata <= (cfg_req && !cfg_write) ? rd_mux : 32'h0000_0000;
      end
   end

   // Interrupt routing byte, read/write, no hardware effect
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         irq_routing_note <= BCH_IRQ_NOTE_RST;
      end else if (wr_note) begin
         irq_routing_note <= cfg_wdata[7:0];
      end
   end

   // Bridge control upper byte; writes elsewhere leave read-only fields alone
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         disc_serr_en <= BCH_SEC_CTRL_RST[BCH_BIT_DISC_SERR_EN];
         sec_disc_sel <= BCH_SEC_CTRL_RST[BCH_BIT_SEC_DISC_SEL];
         pri_disc_sel <= BCH_SEC_CTRL_RST[BCH_BIT_PRI_DISC_SEL];
         disc_status  <= BCH_SEC_CTRL_RST[BCH_BIT_DISC_STATUS];
      end else begin
         disc_status <= next_disc_status;
         if (wr_ctl_hi) begin
            disc_serr_en <= ctl_wdata[BCH_BIT_DISC_SERR_EN];
            sec_disc_sel <= ctl_wdata[BCH_BIT_SEC_DISC_SEL];
            pri_disc_sel <= ctl_wdata[BCH_BIT_PRI_DISC_SEL];
         end
      end
   end

   // Bridge control lower byte: only the secondary reset is held here
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sec_reset <= BCH_SEC_CTRL_RST[BCH_BIT_SEC_RESET];
      end else if (wr_ctl_lo) begin
         sec_reset <= ctl_wdata[BCH_BIT_SEC_RESET];
      end
   end

   // Outputs to pins and queue
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sec_bus_reset_n <= 1'b1;
         serr_drive      <= 1'b0;
         pri_dt_discard  <= 1'b0;
         sec_dt_discard  <= 1'b0;
      end else begin
         sec_bus_reset_n <= !next_sec_reset_val;
         serr_drive      <= serr_req;
         pri_dt_discard  <= pri_expire;
         sec_dt_discard  <= sec_expire;
      end
   end

   // Open-drain system error: value always low, enable low while driving
   assign upstream_system_error_out  = 1'b0;
   assign upstream_system_error_oe_n = !serr_drive;

   // Discard timers
   bch_discard_timer #(
      .LONG_CLKS  (LONG_CLKS),
      .SHORT_CLKS (SHORT_CLKS)
   ) u_pri_timer (
      .clk           (clk),
      .rstn          (rstn),
      .start         (pri_dt_complete),
      .master_repeat (pri_dt_repeat),
      .short_sel     (pri_disc_sel),
      .running       (pri_running),
      .expire        (pri_expire)
   );

   bch_discard_timer #(
      .LONG_CLKS  (LONG_CLKS),
      .SHORT_CLKS (SHORT_CLKS)
   ) u_sec_timer (
      .clk           (clk),
      .rstn          (rstn),
      .start         (sec_dt_complete),
      .master_repeat (sec_dt_repeat),
      .short_sel     (sec_disc_sel),
      .running       (sec_running),
      .expire        (sec_expire)
   );

endmodule : bch_config_tail

// >>> tb/bch_tail_sva.sv
// Checker for the config tail: fixed reads, lane steering and discard signalling.
// Bound to every config tail instance; sees only its ports.
module bch_tail_sva
   import bch_pkg::*;
#(
   parameter int LONG_CLKS  = 64,
   parameter int SHORT_CLKS = 8
) (
   // Clock and reset
   input wire logic        clk,
   input wire logic        rstn,
   // Configuration access
   input wire logic        cfg_req,
   input wire logic        cfg_write,
   input wire logic [7:0]  cfg_addr,
   input wire logic [3:0]  cfg_byte_en_n,
   input wire logic [31:0] cfg_wdata,
   input wire logic        cfg_ack,
   input wire logic        cfg_hit,
   input wire logic [31:0] cfg_rdata,
   // Command and events
   input wire logic        serr_enable,
   input wire logic        pri_dt_complete,
   input wire logic        pri_dt_repeat,
   input wire logic        sec_dt_complete,
   input wire logic        sec_dt_repeat,
   input wire logic        pri_dt_discard,
   input wire logic        sec_dt_discard,
   // Outputs to the buses
   input wire logic        upstream_system_error_out,
   input wire logic        upstream_system_error_oe_n,
   input wire logic        sec_bus_reset_n
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   wire       rd_req = cfg_req && !cfg_write;
   wire [5:0] dw     = cfg_addr[7:2];
   a_ack_one_cycle: assert property (cfg_ack == $past(cfg_req))
      else $error("ack not one cycle after request");
   a_cap_head_read: assert property (rd_req && dw == 6'h0d |=> cfg_rdata == 32'h0000_00dc)
      else $error("capability head wrong");
   a_rom_base_zero: assert property (rd_req && dw == 6'h0e |=> cfg_rdata == 32'h0)
      else $error("option rom base not zero");
   a_irq_pin_zero: assert property (rd_req && dw == 6'h0f |=> cfg_rdata[15:8] == 8'h00)
      else $error("irq terminal byte not zero");
   a_ctrl_fixed_zero: assert property (rd_req && dw == 6'h0f |=>
      cfg_rdata[31:28] == 4'h0 && !cfg_rdata[23])
      else $error("fixed control bits not zero");
   a_sec_reset_follows: assert property (cfg_req && cfg_write && dw == 6'h0f
      && !cfg_byte_en_n[2] |=> sec_bus_reset_n == !$past(cfg_wdata[22]))
      else $error("secondary reset does not follow control");
   a_serr_only_pri: assert property (!upstream_system_error_oe_n |->
      pri_dt_discard && !upstream_system_error_out && $past(serr_enable))
      else $error("error line driven without cause");
   a_pri_no_early: assert property (pri_dt_complete |=> !pri_dt_discard [*8])
      else $error("primary discard too early");
   a_sec_no_early: assert property (sec_dt_complete |=> !sec_dt_discard [*8])
      else $error("secondary discard too early");
   c_pri_disc: cover property (pri_dt_discard);
   c_sec_disc: cover property (sec_dt_discard);
   c_serr: cover property (!upstream_system_error_oe_n);
endmodule : bch_tail_sva

bind bch_config_tail bch_tail_sva #(.LONG_CLKS(LONG_CLKS), .SHORT_CLKS(SHORT_CLKS)) i_sva (
   .clk(clk), .rstn(rstn), .cfg_req(cfg_req), .cfg_write(cfg_write), .cfg_addr(cfg_addr),
   .cfg_byte_en_n(cfg_byte_en_n), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack),
   .cfg_hit(cfg_hit), .cfg_rdata(cfg_rdata), .serr_enable(serr_enable),
   .pri_dt_complete(pri_dt_complete), .pri_dt_repeat(pri_dt_repeat),
   .sec_dt_complete(sec_dt_complete), .sec_dt_repeat(sec_dt_repeat),
   .pri_dt_discard(pri_dt_discard), .sec_dt_discard(sec_dt_discard),
   .upstream_system_error_out(upstream_system_error_out),
   .upstream_system_error_oe_n(upstream_system_error_oe_n),
   .sec_bus_reset_n(sec_bus_reset_n)
);

// >>> tb/bch_bus_model.sv
// Bus side stand-in: delayed transaction events and the pulled-up error line.
// Assumes its task is called just after a rising clock edge.
module bch_bus_model (
   // Clock
   input  wire logic clk,
   // Open-drain error line from the bridge
   input  wire logic upstream_system_error_out,
   input  wire logic upstream_system_error_oe_n,
   output logic      serr_wire,
   // Delayed transaction events
   output logic      pri_dt_complete,
   output logic      pri_dt_repeat,
   output logic      sec_dt_complete,
   output logic      sec_dt_repeat
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] ev = 4'h0;
   assign serr_wire = upstream_system_error_oe_n ? 1'b1 : upstream_system_error_out;
   assign {sec_dt_repeat, sec_dt_complete, pri_dt_repeat, pri_dt_complete} = ev;
   // One-cycle event: 0 pri done, 1 pri repeat, 2 sec done, 3 sec repeat
   task pulse(input int k);
      @(posedge clk);
      #5 ev[k] = 1'b1;
      @(posedge clk);
      #5 ev = 4'h0;
   endtask : pulse
endmodule : bch_bus_model

// >>> tb/tb_top.sv
// Self-checking bench for the config tail: register map, control bits, discard timers.
// Assumes the bus model and the bound checker are compiled with it.
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int LONG  = 64;
   localparam int SHORT = 8;
   logic        clk = 0, rstn = 0, cfg_req = 0, cfg_write = 0, serr_enable = 0;
   logic [7:0]  cfg_addr = 0;
   logic [3:0]  cfg_byte_en_n = 4'hf;
   logic [31:0] cfg_wdata = 0, rd, cfg_rdata;
   logic        cfg_ack, cfg_hit, pri_dt_discard, sec_dt_discard, sec_bus_reset_n, serr_wire;
   logic        upstream_system_error_out, upstream_system_error_oe_n;
   logic        pri_dt_complete, pri_dt_repeat, sec_dt_complete, sec_dt_repeat;
   logic        hit_seen = 0;
   int          err_total = 0, compares = 0, serr_cnt = 0;
   bch_config_tail #(.LONG_CLKS(LONG), .SHORT_CLKS(SHORT)) i_dut (
      .clk(clk), .rstn(rstn), .cfg_req(cfg_req), .cfg_write(cfg_write), .cfg_addr(cfg_addr),
      .cfg_byte_en_n(cfg_byte_en_n), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack),
      .cfg_hit(cfg_hit), .cfg_rdata(cfg_rdata), .serr_enable(serr_enable),
      .pri_dt_complete(pri_dt_complete), .pri_dt_repeat(pri_dt_repeat),
      .sec_dt_complete(sec_dt_complete), .sec_dt_repeat(sec_dt_repeat),
      .pri_dt_discard(pri_dt_discard), .sec_dt_discard(sec_dt_discard),
      .upstream_system_error_out(upstream_system_error_out),
      .upstream_system_error_oe_n(upstream_system_error_oe_n),
      .sec_bus_reset_n(sec_bus_reset_n)
   );
   bch_bus_model i_model (
      .clk(clk), .upstream_system_error_out(upstream_system_error_out),
      .upstream_system_error_oe_n(upstream_system_error_oe_n), .serr_wire(serr_wire),
      .pri_dt_complete(pri_dt_complete), .pri_dt_repeat(pri_dt_repeat),
      .sec_dt_complete(sec_dt_complete), .sec_dt_repeat(sec_dt_repeat)
   );
   always #25 clk = ~clk;
   always @(negedge clk) if (serr_wire === 1'b0) serr_cnt++;
   task chk(input string nm, input logic [31:0] exp, got);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %s exp %h got %h", nm, exp, got);
      end
   endtask : chk
   task cfg(input logic wr, input logic [7:0] a, input logic [3:0] ben, input logic [31:0] d);
      {cfg_req, cfg_write, cfg_addr, cfg_byte_en_n, cfg_wdata} = {1'b1, wr, a, ben, d};
      @(posedge clk);
      #5 cfg_req = 0;
      rd = cfg_rdata;
      hit_seen = cfg_hit;
      chk("ack", 1, cfg_ack);
      @(posedge clk);
      #5;
   endtask : cfg
   // Start a timer, time the discard, then check error line and status
   task disc(input int k, input int lim, input int serr_exp);
      int n, s;
      s = serr_cnt;
      n = 0;
      i_model.pulse(k);
      while ((k ? sec_dt_discard : pri_dt_discard) !== 1'b1 && n < lim + 8) begin
         @(posedge clk);
         #5 n++;
      end
      chk("disc_wait", 1, 32'(n >= lim && n <= lim + 4));
      @(posedge clk);
      #5 chk("serr", 32'(serr_exp), 32'(serr_cnt - s));
      cfg(0, 8'h3c, 4'h0, 0);
      chk("disc_status", 1, rd[26]);
   endtask : disc
   task tally_and_finish;
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : tally_and_finish
   initial begin
      #100000 err_total++;
      tally_and_finish;
   end
   initial begin
      repeat (16) @(posedge clk);
      #5 rstn = 1;
      cfg(0, 8'h34, 4'h0, 0);
      chk("cap", 32'hdc, rd);
      chk("cap_hit", 1, hit_seen);
      cfg(1, 8'h34, 4'h0, 32'hffffffff);
      cfg(0, 8'h34, 4'h0, 0);
      chk("cap_wr", 32'hdc, rd);
      cfg(1, 8'h38, 4'h0, 32'hffffffff);
      cfg(0, 8'h38, 4'h0, 0);
      chk("rom", 32'h0, rd);
      cfg(0, 8'h3c, 4'h0, 0);
      chk("tail_rst", 32'h0, rd);
      chk("srst_rst", 1, sec_bus_reset_n);
      cfg(0, 8'h40, 4'h0, 0);
      chk("unmapped", 0, rd);
      chk("unmapped_hit", 0, hit_seen);
      cfg(1, 8'h3c, 4'h0, 32'hffffffff);
      chk("srst_on", 0, sec_bus_reset_n);
      cfg(0, 8'h3c, 4'h0, 0);
      chk("tail_ones", 32'h0b4000ff, rd);
      cfg(1, 8'h3c, 4'he, 32'h12);
      cfg(1, 8'h3c, 4'h3, 32'h0b000000);
      chk("srst_off", 1, sec_bus_reset_n);
      cfg(0, 8'h3c, 4'h0, 0);
      chk("lanes", 32'h0b000012, rd);
      serr_enable = 1;
      disc(0, SHORT, 1);
      cfg(1, 8'h3c, 4'h7, 32'h0b000000);
      cfg(0, 8'h3c, 4'h0, 0);
      chk("status_held", 1, rd[26]);
      cfg(1, 8'h3c, 4'h7, 32'h0f000000);
      cfg(0, 8'h3c, 4'h0, 0);
      chk("status_clr", 32'h0b000012, rd);
      disc(2, SHORT, 0);
      cfg(1, 8'h3c, 4'h7, 32'h0f000000);
      i_model.pulse(2);
      repeat (3) @(posedge clk);
      #5 i_model.pulse(3);
      repeat (20) @(posedge clk);
      #5 cfg(0, 8'h3c, 4'h0, 0);
      chk("no_discard", 0, rd[26]);
      serr_enable = 0;
      disc(0, SHORT, 0);
      serr_enable = 1;
      cfg(1, 8'h3c, 4'h7, 32'h04000000);
      disc(0, LONG, 0);
      cfg(1, 8'h3c, 4'h7, 32'h04000000);
      disc(2, LONG, 0);
      tally_and_finish;
   end
endmodule : tb_top
